/* hw/wse_defines.vh */
`ifndef WSE_DEFINES_VH
`define WSE_DEFINES_VH

// register indices; byte address is four times the index
`define WSE_IDX_WSTS1 6'h02
`define WSE_IDX_WSTS2 6'h03
`define WSE_IDX_WSTS3 6'h04
`define WSE_IDX_WEN1 6'h05
`define WSE_IDX_WEN2 6'h06
`define WSE_IDX_WEN3 6'h07
`define WSE_IDX_SMI_EVENT_STATUS_PINS 6'h08
`define WSE_IDX_SMI_EVENT_STATUS_UNITS 6'h09
`define WSE_IDX_SMI_EN1 6'h0A
`define WSE_IDX_SMI_EN2 6'h0B
`define WSE_IDX_IRQ_STS 6'h10
`define WSE_IDX_IRQ_MASK 6'h11

// reset values on standby power-on reset
`define WSE_RST_WEN 8'h00
`define WSE_RST_WSTS 8'h00
`define WSE_RST_SMI_EVENT_STATUS_PINS 8'h00
`define WSE_RST_SMI_EVENT_STATUS_UNITS 6'h01
`define WSE_RST_SMI_EN 8'h00
`define WSE_RST_IRQ 2'h0

// writable masks; reserved bits hold zero
`define WSE_WEN2_MASK 8'h7F
`define WSE_WSTS2_MASK 8'h7F

// field positions in the unit status register
`define WSE_S2_PAR 0
`define WSE_S2_UARTB 1
`define WSE_S2_UARTA 2
`define WSE_S2_FLOP 3
`define WSE_S2_GPIO_PIN_2_3 4
`define WSE_S2_GPIO_PIN_2_4 5
`define WSE_S2_LIVE_MASK 6'h0F
`define WSE_S2_STICKY_MASK 6'h30

// smi enable group 2 routing bits
`define WSE_SMIEN2_SERIAL 6
`define WSE_SMIEN2_PIN 7

// interrupt status fields
`define WSE_IRQ_WAKE 0
`define WSE_IRQ_SMI 1

`endif

/* hw/wse_edge.v */
`timescale 1ns/1ps

// rising-edge detector for a group of level inputs
module wse_edge #(
  parameter W = 8
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] sig,
  output wire [W-1:0] rise
);

  reg [W-1:0] prev_q;

  // previous level, cleared by standby reset only
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= {W{1'b0}};
    end else begin
      prev_q <= sig;
    end
  end

  // a level already high at reset release counts as one event
  assign rise = sig & ~prev_q;

endmodule // wse_edge

/* hw/wse_top.v */
`timescale 1ns/1ps
`include "wse_defines.vh"

// Function
// R1: wake enable group 1 at 05 enables pins 10..17 onto wake output.
// R2: wake output low when enable, status and global enable are all one.
// R3: disabled sources still set wake status but never drive wake output.
// R4: wake enable group 2 at 06: ring a, ring b, pins 20..24, bit 7 reserved.
// R5: wake enable group 3 at 07 enables pins 30..37 onto wake output.
// R6: wake enables reset to 00 only on standby reset, kept through others.
// R7: smi pin status at 08, pins 10..17, write one clears, resets 00.
// R8: unit status bits 3..0 ignore writes, follow source; bits 5..4 write-one-clear.
// R9: unit status at 09: parallel, uart b, uart a, floppy, pins 23, 24.
// R10: parallel bit reads one while inactive, else follows acknowledge input.
// R11: unit status resets to 01; bit 0 forced on main reset, hard reset.
// R12: wake status set by source event regardless of enables; write one clears.
// R13: smi enable bits gate each smi status source onto grouped smi signal.
// R14: reserved bits always read zero whatever software writes.
// R15: global wake enable is an input, anded with enable and status terms.
module wse_top (
  input wire clk,
  input wire rst,
  input wire main_por,
  input wire hard_reset,
  input wire global_wake_enable,
  input wire [7:0] gpio_pin_1,
  input wire [4:0] gpio_pin_2,
  input wire [7:0] gpio_pin_3,
  input wire ring_indicator_a,
  input wire ring_indicator_b,
  input wire parallel_port_active,
  input wire printer_acknowledge_n,
  input wire uart_b_irq,
  input wire uart_a_irq,
  input wire floppy_irq,
  input wire wb_cyc,
  input wire wb_stb,
  input wire wb_we,
  input wire [7:0] wb_adr,
  input wire [3:0] wb_sel,
  input wire [31:0] wb_dat_w,
  output wire [31:0] wb_dat_r,
  output wire wb_ack,
  output wire wake_out_n,
  output wire smi_out_n,
  output wire smi_serial,
  output wire irq
);

  // wake enables and wake status
  reg [7:0] wen1_q;
  reg [7:0] wen2_q;
  reg [7:0] wen3_q;
  reg [7:0] wsts1_q;
  reg [7:0] wsts2_q;
  reg [7:0] wsts3_q;
  // smi status and enables
  reg [7:0] smi_event_status_pins_q;
  reg [5:0] smi_event_status_units_q;
  reg [5:0] smi_event_status_units_d;
  reg [7:0] smi_en1_q;
  reg [7:0] smi_en2_q;
  // block interrupt
  reg [1:0] irq_sts_q;
  reg [1:0] irq_mask_q;
  reg irq_q;
  // outputs and bus
  reg wake_out_n_q;
  reg smi_out_n_q;
  reg smi_serial_q;
  reg smi_grp_q;
  reg ack_q;
  reg [7:0] dat_r_q;
  reg [7:0] rd_d;

  wire [7:0] rise1;
  wire [4:0] rise2;
  wire [7:0] rise3;
  wire [1:0] rise_ri;
  wire [5:0] idx;
  wire req;
  wire wr;
  wire [7:0] wd;
  wire [7:0] wsts2_set;
  wire wake_lvl;
  wire smi_grp;
  wire [1:0] irq_evt;
  wire wake_hit1;
  wire wake_hit2;
  wire wake_hit3;
  wire smi_hit_pins;
  wire smi_hit_units;
  wire [7:0] s2_next;
  wire [7:0] irq_next;

  // set wins over clear so an event in the clearing cycle survives
  function [7:0] w1c;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    begin
      w1c = (cur & ~clr) | set;
    end
  endfunction

  // write-one mask for a register, zero unless this index is written
  function [7:0] clr_at;
    input do_wr;
    input [5:0] at;
    input [5:0] want;
    input [7:0] data;
    begin
      clr_at = (do_wr && at == want) ? data : 8'h00;
    end
  endfunction

  // true when any source has both its enable and its status set
  function any_hit;
    input [7:0] en;
    input [7:0] sts;
    begin
      any_hit = |(en & sts);
    end
  endfunction

  // event capture for each source group
  wse_edge #(.W(8)) u_edge1 (
    .clk(clk),
    .rst(rst),
    .sig(gpio_pin_1),
    .rise(rise1)
  );

  wse_edge #(.W(5)) u_edge2 (
    .clk(clk),
    .rst(rst),
    .sig(gpio_pin_2),
    .rise(rise2)
  );

  wse_edge #(.W(8)) u_edge3 (
    .clk(clk),
    .rst(rst),
    .sig(gpio_pin_3),
    .rise(rise3)
  );

  wse_edge #(.W(2)) u_edge_ri (
    .clk(clk),
    .rst(rst),
    .sig({ring_indicator_b, ring_indicator_a}),
    .rise(rise_ri)
  );

  // bus decode; a request is served once, ack drops the cycle after
  assign idx = wb_adr[7:2];
  assign req = wb_cyc & wb_stb & ~ack_q;
  assign wr = req & wb_we & wb_sel[0];
  assign wd = wb_dat_w[7:0];

  // group 2 status sources: ring a, ring b, then pins 20..24
  assign wsts2_set = {1'b0, rise2, rise_ri}; // [R4]

  // per-group wake hits; a source counts only with its enable and status both set
  assign wake_hit1 = any_hit(wen1_q, wsts1_q); // [R1] [R3]
  assign wake_hit2 = any_hit(wen2_q, wsts2_q); // [R4] [R3]
  assign wake_hit3 = any_hit(wen3_q, wsts3_q); // [R5] [R3]

  // wake level: any group hit, gated by the global enable kept outside this block
  assign wake_lvl = global_wake_enable & (wake_hit1 | wake_hit2 | wake_hit3); // [R2] [R15]

  // grouped smi: every status bit against its own enable
  assign smi_hit_pins = any_hit(smi_en1_q, smi_event_status_pins_q); // [R13]
  assign smi_hit_units = any_hit(smi_en2_q & 8'h3F, {2'b00, smi_event_status_units_q}); // [R13]
  assign smi_grp = smi_hit_pins | smi_hit_units;

  // unit sticky bits; a pin edge wins over a clearing write in the same cycle
  assign s2_next = w1c({2'b00, smi_event_status_units_q}, {2'b00, rise2[4:3], 4'h0},
    clr_at(wr, idx, `WSE_IDX_SMI_EVENT_STATUS_UNITS, wd)); // [R8]

  // block interrupt status next value; a new event beats the clearing write
  assign irq_next = w1c({6'h00, irq_sts_q}, {6'h00, irq_evt},
    clr_at(wr, idx, `WSE_IDX_IRQ_STS, wd));

  // block events: wake going active, grouped smi going active
  assign irq_evt = {smi_grp & ~smi_grp_q, wake_lvl & wake_out_n_q};

  // wake enables: only the standby reset clears them
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wen1_q <= `WSE_RST_WEN; // [R6]
      wen2_q <= `WSE_RST_WEN; // [R6]
      wen3_q <= `WSE_RST_WEN; // [R6]
    end else if (wr) begin
      if (idx == `WSE_IDX_WEN1) begin
        wen1_q <= wd; // [R1]
      end
      if (idx == `WSE_IDX_WEN2) begin
        wen2_q <= wd & `WSE_WEN2_MASK; // [R4] [R14]
      end
      if (idx == `WSE_IDX_WEN3) begin
        wen3_q <= wd; // [R5]
      end
    end
  end

  // wake status: set by events regardless of enables, write one clears
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wsts1_q <= `WSE_RST_WSTS;
      wsts2_q <= `WSE_RST_WSTS;
      wsts3_q <= `WSE_RST_WSTS;
    end else begin
      wsts1_q <= w1c(wsts1_q, rise1, clr_at(wr, idx, `WSE_IDX_WSTS1, wd)); // [R12]
      wsts2_q <= w1c(wsts2_q, wsts2_set, clr_at(wr, idx, `WSE_IDX_WSTS2, wd)) & `WSE_WSTS2_MASK; // [R12] [R14]
      wsts3_q <= w1c(wsts3_q, rise3, clr_at(wr, idx, `WSE_IDX_WSTS3, wd)); // [R12]
    end
  end

  // smi pin status: pin events, write one clears
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      smi_event_status_pins_q <= `WSE_RST_SMI_EVENT_STATUS_PINS; // [R7]
    end else begin
      smi_event_status_pins_q <= w1c(smi_event_status_pins_q, rise1, clr_at(wr, idx, `WSE_IDX_SMI_EVENT_STATUS_PINS, wd)); // [R7]
    end
  end

  // unit status next value; live bits track sources, writes never reach them
  always @* begin
    smi_event_status_units_d = smi_event_status_units_q;
    smi_event_status_units_d[`WSE_S2_UARTB] = uart_b_irq; // [R8] [R9]
    smi_event_status_units_d[`WSE_S2_UARTA] = uart_a_irq; // [R8] [R9]
    smi_event_status_units_d[`WSE_S2_FLOP] = floppy_irq; // [R8] [R9]
    // parallel bit idles high while the port is not activated
    if (!parallel_port_active) begin
      smi_event_status_units_d[`WSE_S2_PAR] = 1'b1; // [R10]
    end else begin
      smi_event_status_units_d[`WSE_S2_PAR] = printer_acknowledge_n; // [R10]
    end
    // sticky pin bits 4 and 5 from pins 23 and 24
    smi_event_status_units_d[5:4] = s2_next[5:4]; // [R8] [R9]
    // main-supply and hard resets force the parallel bit
    if (main_por || hard_reset) begin
      smi_event_status_units_d[`WSE_S2_PAR] = 1'b1; // [R11]
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      smi_event_status_units_q <= `WSE_RST_SMI_EVENT_STATUS_UNITS; // [R11]
    end else begin
      smi_event_status_units_q <= smi_event_status_units_d;
    end
  end

  // smi enables, plain read/write
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      smi_en1_q <= `WSE_RST_SMI_EN;
      smi_en2_q <= `WSE_RST_SMI_EN;
    end else if (wr) begin
      if (idx == `WSE_IDX_SMI_EN1) begin
        smi_en1_q <= wd;
      end
      if (idx == `WSE_IDX_SMI_EN2) begin
        smi_en2_q <= wd;
      end
    end
  end

  // block interrupt status and mask
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_sts_q <= `WSE_RST_IRQ;
      irq_mask_q <= `WSE_RST_IRQ;
    end else begin
      irq_sts_q <= irq_next[1:0];
      if (wr && idx == `WSE_IDX_IRQ_MASK) begin
        irq_mask_q <= wd[1:0];
      end
    end
  end

  // registered outputs; one cycle behind the status they reflect
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_out_n_q <= 1'b1;
      smi_out_n_q <= 1'b1;
      smi_serial_q <= 1'b0;
      smi_grp_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      wake_out_n_q <= ~wake_lvl; // [R2]
      smi_out_n_q <= ~(smi_grp & smi_en2_q[`WSE_SMIEN2_PIN]);
      smi_serial_q <= smi_grp & smi_en2_q[`WSE_SMIEN2_SERIAL];
      smi_grp_q <= smi_grp;
      irq_q <= |(irq_sts_q & irq_mask_q);
    end
  end

  // read mux; unmapped indices and reserved bits read zero
  always @* begin
    rd_d = 8'h00;
    case (idx)
      `WSE_IDX_WSTS1: rd_d = wsts1_q;
      `WSE_IDX_WSTS2: rd_d = wsts2_q;
      `WSE_IDX_WSTS3: rd_d = wsts3_q;
      `WSE_IDX_WEN1: rd_d = wen1_q;
      `WSE_IDX_WEN2: rd_d = wen2_q; // [R14]
      `WSE_IDX_WEN3: rd_d = wen3_q;
      `WSE_IDX_SMI_EVENT_STATUS_PINS: rd_d = smi_event_status_pins_q;
      `WSE_IDX_SMI_EVENT_STATUS_UNITS: rd_d = {2'b00, smi_event_status_units_q}; // [R14]
      `WSE_IDX_SMI_EN1: rd_d = smi_en1_q;
      `WSE_IDX_SMI_EN2: rd_d = smi_en2_q;
      `WSE_IDX_IRQ_STS: rd_d = {6'h00, irq_sts_q};
      `WSE_IDX_IRQ_MASK: rd_d = {6'h00, irq_mask_q};
      default: rd_d = 8'h00;
    endcase
  end

  // bus answer: ack one cycle after the request, data captured with it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      dat_r_q <= 8'h00;
    end else begin
      ack_q <= req;
      if (req && !wb_we) begin
        dat_r_q <= rd_d;
      end
    end
  end

  assign wb_ack = ack_q;
  assign wb_dat_r = {24'h000000, dat_r_q};
  assign wake_out_n = wake_out_n_q;
  assign smi_out_n = smi_out_n_q;
  assign smi_serial = smi_serial_q;
  assign irq = irq_q;

endmodule // wse_top

/* bench/wse_top_props.sv */
`timescale 1ns/1ps
// bus handshake, wake gating and unit status read-back
module wse_top_props (
  input wire clk,
  input wire rst,
  input wire main_por,
  input wire hard_reset,
  input wire global_wake_enable,
  input wire parallel_port_active,
  input wire printer_acknowledge_n,
  input wire uart_b_irq,
  input wire uart_a_irq,
  input wire floppy_irq,
  input wire wb_cyc,
  input wire wb_stb,
  input wire wb_we,
  input wire [7:0] wb_adr,
  input wire [31:0] wb_dat_r,
  input wire wb_ack,
  input wire wake_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // expected live unit bits; forced resets are kept out of steady windows
  wire [3:0] unit_exp = {floppy_irq, uart_a_irq, uart_b_irq, parallel_port_active ? printer_acknowledge_n : 1'b1};
  wire [5:0] unit_src = {unit_exp, main_por, hard_reset};
  wire take = wb_cyc && wb_stb && !wb_ack;
  sequence s_rd(idx);
    take && !wb_we && wb_adr[7:2] == idx;
  endsequence
  sequence s_steady;
    ($stable(unit_src) && !main_por && !hard_reset)[*2];
  endsequence
  AST_ACK_AFTER_REQ: assert property (take |=> wb_ack)
    else $error("request not acknowledged in next cycle");
  AST_ACK_PULSE: assert property (wb_ack |=> !wb_ack)
    else $error("ack longer than one cycle");
  AST_ACK_IDLE: assert property (!(wb_cyc && wb_stb) |=> !wb_ack)
    else $error("ack without request");
  AST_DAT_UPPER: assert property (wb_ack |-> wb_dat_r[31:8] == 24'h000000)
    else $error("upper read data not zero");
  AST_WAKE_GLOBAL: assert property (!global_wake_enable |=> wake_out_n)
    else $error("wake driven while global enable low");
  AST_EN2_RSVD: assert property (s_rd(6'h06) |=> !wb_dat_r[7])
    else $error("reserved enable bit read one");
  AST_UNIT_RSVD: assert property (s_rd(6'h09) |=> wb_dat_r[7:6] == 2'h0)
    else $error("reserved unit bits read nonzero");
  AST_UNIT_LIVE: assert property (s_steady ##0 s_rd(6'h09) |=> wb_dat_r[3:0] == $past(unit_exp))
    else $error("unit bits do not follow sources");
  AST_UNIT_FORCE: assert property ((main_por || hard_reset)[*2] ##0 s_rd(6'h09) |=> wb_dat_r[0])
    else $error("parallel bit not forced by reset");
endmodule // wse_top_props

bind wse_top wse_top_props u_props (.*);

/* bench/wse_host_model.sv */
`timescale 1ns/1ps
// host side: counts wake requests it would act on
module wse_host_model (
  input wire clk,
  input wire rst,
  input wire wake_out_n,
  output logic [7:0] wake_seen
);
  logic prev_q;
  // count falling edges only, a held request is one wake
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_seen <= 8'h00;
      prev_q <= 1'b1;
    end else begin
      prev_q <= wake_out_n;
      if (prev_q && !wake_out_n) wake_seen <= wake_seen + 8'h01;
    end
  end
endmodule // wse_host_model

/* bench/wse_top_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks += 1; if ((a) !== (b)) begin n_fail += 1; $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module wse_top_tb_top;
  logic clk = 0, rst = 1, mpor = 0, hrst = 0, gwe = 0, ppa = 0, ack_n = 1, ub = 0, ua = 0, fl = 0;
  logic ria = 0, rib = 0, cyc = 0, stb = 0, we = 0, q;
  logic [7:0] g1 = 0, g3 = 0, adr = 0, rd;
  logic [4:0] g2 = 0;
  logic [3:0] sel = 0;
  logic [31:0] dw = 0;
  wire [31:0] dr;
  wire [7:0] wake_seen;
  wire ack, wake_n, smi_n, smi_s, irq;
  wire [3:0] outs = {irq, smi_s, smi_n, wake_n};
  int n_fail = 0, num_checks = 0, k;
  always #5 clk = ~clk;
  wse_top dut (.clk(clk), .rst(rst), .main_por(mpor), .hard_reset(hrst), .global_wake_enable(gwe),
    .gpio_pin_1(g1), .gpio_pin_2(g2), .gpio_pin_3(g3), .ring_indicator_a(ria), .ring_indicator_b(rib),
    .parallel_port_active(ppa), .printer_acknowledge_n(ack_n), .uart_b_irq(ub), .uart_a_irq(ua),
    .floppy_irq(fl), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_dat_w(dw),
    .wb_dat_r(dr), .wb_ack(ack), .wake_out_n(wake_n), .smi_out_n(smi_n), .smi_serial(smi_s), .irq(irq));
  wse_host_model host (.clk(clk), .rst(rst), .wake_out_n(wake_n), .wake_seen(wake_seen));
  task end_of_test;
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one classic cycle, ack awaited under a bound
  task bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int i;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h1;
    dw <= {24'h000000, d};
    i = 0;
    @(posedge clk);
    while (ack !== 1'b1 && i < 20) begin
      i++;
      @(posedge clk);
    end
    if (i >= 20) begin
      n_fail += 1;
      end_of_test;
    end
    rd = dr[7:0];
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task rchk(input logic [5:0] idx, input logic [7:0] e);
    bus(0, idx, 8'h00);
    `CHK(rd, e)
  endtask
  // wake takes two edges from the input to the output, the third edge is margin
  task lchk(input logic [3:0] m, input logic [3:0] e);
    repeat (3) @(posedge clk);
    `CHK(outs & m, e)
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    for (k = 5; k < 9; k++) rchk(k[5:0], 8'h00);
    rchk(6'h09, 8'h01);
    for (k = 5; k < 8; k++) bus(1, k[5:0], 8'hFF);
    rchk(6'h05, 8'hFF);
    rchk(6'h06, 8'h7F);
    rchk(6'h07, 8'hFF);
    rchk(6'h3F, 8'h00);
    mpor <= 1;
    hrst <= 1;
    repeat (2) @(posedge clk);
    mpor <= 0;
    hrst <= 0;
    rchk(6'h05, 8'hFF);
    bus(1, 6'h05, 8'h01);
    bus(1, 6'h06, 8'h01);
    bus(1, 6'h07, 8'h80);
    // disabled source first, then enabled source with global enable off
    gwe <= 1;
    g1 <= 8'h02;
    lchk(4'h1, 4'h1);
    rchk(6'h02, 8'h02);
    gwe <= 0;
    g1 <= 8'h03;
    lchk(4'h1, 4'h1);
    gwe <= 1;
    lchk(4'h1, 4'h0);
    bus(1, 6'h02, 8'h00);
    rchk(6'h02, 8'h03);
    bus(1, 6'h02, 8'h03);
    lchk(4'h1, 4'h1);
    ria <= 1;
    lchk(4'h1, 4'h0);
    bus(1, 6'h03, 8'h01);
    lchk(4'h1, 4'h1);
    g3 <= 8'h80;
    lchk(4'h1, 4'h0);
    bus(1, 6'h04, 8'h80);
    `CHK(wake_seen, 8'h03)
    rchk(6'h08, 8'h03);
    bus(1, 6'h08, 8'h01);
    rchk(6'h08, 8'h02);
    bus(1, 6'h0B, 8'hC0);
    lchk(4'h6, 4'h2);
    bus(1, 6'h0A, 8'h02);
    lchk(4'h6, 4'h4);
    bus(1, 6'h0B, 8'h80);
    lchk(4'h6, 4'h0);
    bus(1, 6'h08, 8'h02);
    lchk(4'h6, 4'h2);
    // live unit bits against a sticky pin bit
    ppa <= 1;
    ack_n <= 0;
    ub <= 1;
    fl <= 1;
    g2 <= 5'h08;
    repeat (3) @(posedge clk);
    rchk(6'h09, 8'h1A);
    bus(1, 6'h09, 8'hFF);
    rchk(6'h09, 8'h0A);
    ack_n <= 1;
    ub <= 0;
    ua <= 1;
    fl <= 0;
    g2 <= 5'h18;
    repeat (3) @(posedge clk);
    rchk(6'h09, 8'h25);
    ppa <= 0;
    ack_n <= 0;
    ua <= 0;
    rchk(6'h09, 8'h21);
    ppa <= 1;
    hrst <= 1;
    rchk(6'h09, 8'h21);
    hrst <= 0;
    bus(1, 6'h0B, 8'hA0);
    lchk(4'h6, 4'h0);
    // mask polarity is left open, so masking must flip the output
    rchk(6'h10, 8'h03);
    bus(1, 6'h11, 8'h00);
    repeat (2) @(posedge clk);
    q = irq;
    bus(1, 6'h11, 8'h03);
    repeat (2) @(posedge clk);
    `CHK(irq, ~q)
    bus(1, 6'h10, 8'h03);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    rchk(6'h05, 8'h00);
    end_of_test;
  end
endmodule // wse_top_tb_top
